// ### include/mcvd_defs.vh
// Constants for the channel voice decoder: status codes, controllers, register map
`ifndef MCVD_DEFS_VH
`define MCVD_DEFS_VH
// Status high nibbles
`define MCVD_ST_NOTE_OFF   4'h8
`define MCVD_ST_NOTE_ON    4'h9
`define MCVD_ST_CTRL       4'hB
`define MCVD_ST_PROG       4'hC
`define MCVD_ST_BEND       4'hE
// Controller numbers
`define MCVD_CC_BANK_HI    7'h00
`define MCVD_CC_MOD        7'h01
`define MCVD_CC_PORTA_TIME 7'h05
`define MCVD_CC_DATA_HI    7'h06
`define MCVD_CC_VOLUME     7'h07
`define MCVD_CC_PAN        7'h0A
`define MCVD_CC_EXPR       7'h0B
`define MCVD_CC_BANK_LO    7'h20
`define MCVD_CC_DATA_LO    7'h26
`define MCVD_CC_SUSTAIN    7'h40
`define MCVD_CC_PORTA_SW   7'h41
`define MCVD_CC_SOSTENUTO  7'h42
`define MCVD_CC_LFO_SPEED  7'h4C
`define MCVD_CC_DRYVAR     7'h5E
`define MCVD_CC_INC        7'h60
`define MCVD_CC_DEC        7'h61
`define MCVD_CC_PARAM_LO   7'h64
`define MCVD_CC_PARAM_HI   7'h65
`define MCVD_CC_SOUND_OFF  7'h78
`define MCVD_CC_RESET_ALL  7'h79
`define MCVD_CC_NOTES_OFF  7'h7B
// Bank classes
`define MCVD_BANK_STD      7'h00
`define MCVD_BANK_PRESET   7'h3F
`define MCVD_BANK_SAMPLE   7'h40
`define MCVD_BANK_PDRUM    7'h7E
`define MCVD_BANK_SDRUM    7'h7F
`define MCVD_BANK_PRE_MAX  7'h09
`define MCVD_BANK_SMP_MAX  7'h01
// Reset values
`define MCVD_BEND_CENTER   14'h2000
`define MCVD_EXPR_MAX      7'h7F
`define MCVD_OFFSET_ZERO   7'h40
`define MCVD_PARAM_NULL    14'h3FFF
`define MCVD_SWITCH_BIT    6
// Register byte addresses
`define MCVD_REG_CTRL      12'h000
`define MCVD_REG_KNOB      12'h004
`define MCVD_REG_TX        12'h008
`define MCVD_REG_CHSEL     12'h00C
`define MCVD_REG_CHSTAT    12'h010
`define MCVD_REG_CHPARAM   12'h014
`define MCVD_REG_NOTE      12'h018
// Control register fields
`define MCVD_CTRL_FOOT_SUS 0
`define MCVD_CTRL_TEMPO    1
`define MCVD_CTRL_RHYTHM   2
`endif

// ### verification/mcvd_link_model.sv
// Far-side instrument model: sends link bytes, sinks transmitted bytes
`timescale 1ns/1ps
module mcvd_link_model (
   input  wire logic       clk,
   input  wire logic       rst,
   output logic            rx_valid,
   output logic [7:0]      rx_byte,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_byte,
   output logic            tx_ready
);
   logic       slow;
   logic [7:0] got[$];
   // ==========================================================
   // Idle values
   initial begin
      slow = 1'b0;
      rx_valid = 1'b0;
      rx_byte = 8'hA5;
   end
   // Send n bytes back to back, highest byte first; idle line toggles
   task automatic send(input logic [23:0] m, input int n);
      int k;
      for (k = n - 1; k >= 0; k--) begin
         @(posedge clk);
         rx_valid <= 1'b1;
         rx_byte <= m[8*k +: 8];
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_byte <= ~m[7:0];
   endtask
   // Sink, stalls every other cycle when slow to exercise holding
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= slow ? ~tx_ready : 1'b1;
         if (tx_valid && tx_ready) got.push_back(tx_byte);
      end
   end
endmodule

// ### verification/mcvd_top_properties.sv
// Port-level checker for the channel voice decoder
`timescale 1ns/1ps
module mcvd_top_properties (
   // Clock and reset
   input wire logic       I_SYS_CLK,
   input wire logic       I_RST,
   // Link streams
   input wire logic       i_rx_valid,
   input wire logic [7:0] i_rx_byte,
   input wire logic       i_tx_ready,
   input wire logic       o_tx_valid,
   input wire logic [7:0] o_tx_byte,
   // Tone generator events
   input wire logic       o_note_valid,
   input wire logic       o_note_on,
   input wire logic [6:0] o_note_vel,
   input wire logic       o_kill_valid
);
   // ==========================================================
   // Event relations
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);
   note_cause_a: assert property (o_note_valid |-> $past(i_rx_valid) && !$past(i_rx_byte[7]))
      else $error("note event without a data byte");
   note_vel_a: assert property (o_note_valid && o_note_on |->
      o_note_vel == $past(i_rx_byte[6:0]) && o_note_vel != 7'h00)
      else $error("note start velocity wrong");
   release_vel_a: assert property (o_note_valid && !o_note_on |-> o_note_vel == 7'h00)
      else $error("release carries velocity");
   kill_cause_a: assert property (o_kill_valid |-> $past(i_rx_valid) && $past(i_rx_byte) == 8'h00)
      else $error("kill without zero value byte");
   event_pulse_a: assert property ((o_note_valid || o_kill_valid) |=>
      !o_note_valid && !o_kill_valid)
      else $error("event pulse too long");
   // ==========================================================
   // Transmit relations
   tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
      else $error("transmit byte changed while stalled");
   tx_status_a: assert property ($rose(o_tx_valid) |->
      o_tx_byte[7:4] == 4'hB || o_tx_byte[7:4] == 4'hE)
      else $error("transmit starts with wrong status");
   tx_frame_a: assert property (o_tx_valid && o_tx_byte[7] && i_tx_ready |->
      ##[1:2] (o_tx_valid && !o_tx_byte[7]))
      else $error("no data byte after status");
endmodule
bind mcvd_top mcvd_top_properties chk_i (.I_SYS_CLK, .I_RST, .i_rx_valid, .i_rx_byte,
   .i_tx_ready, .o_tx_valid, .o_tx_byte, .o_note_valid, .o_note_on, .o_note_vel, .o_kill_valid);

// ### verification/mcvd_top_tb.sv
// Self-checking testbench for the channel voice decoder
`timescale 1ns/1ps
`include "mcvd_defs.vh"
module mcvd_top_tb;
   logic        I_SYS_CLK = 1'b0;
   logic        I_RST = 1'b1;
   logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, o_prdata;
   logic        o_pready, o_pslverr, i_rx_valid, i_tx_ready, o_tx_valid;
   logic [7:0]  i_rx_byte, o_tx_byte;
   logic        i_foot_switch = 1'b0, i_knob_turn = 1'b0;
   logic [6:0]  i_knob_value = 7'h00, o_note_num, o_note_vel;
   logic        o_note_valid, o_note_on, o_kill_valid, o_kill_hard;
   logic [3:0]  o_note_part, o_kill_part;
   logic [18:0] note_ev;
   logic [4:0]  kill_ev;
   logic [31:0] r;
   logic [7:0]  bh, bl;
   int          n_mismatch = 0, checks = 0, cyc = 0, i;
   // ==========================================================
   // Clock, design and far side
   always #20 I_SYS_CLK = ~I_SYS_CLK;
   mcvd_top mcvd_top_i (.I_SYS_CLK, .I_RST, .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rx_valid, .i_rx_byte, .o_tx_valid,
      .o_tx_byte, .i_tx_ready, .i_foot_switch, .i_knob_turn, .i_knob_value, .o_note_valid,
      .o_note_on, .o_note_part, .o_note_num, .o_note_vel, .o_kill_valid, .o_kill_part,
      .o_kill_hard);
   mcvd_link_model link_i (.clk(I_SYS_CLK), .rst(I_RST), .rx_valid(i_rx_valid),
      .rx_byte(i_rx_byte), .tx_valid(o_tx_valid), .tx_byte(o_tx_byte), .tx_ready(i_tx_ready));
   // Latch last events; pulses last one cycle so sample every edge
   always @(posedge I_SYS_CLK) begin
      cyc++;
      if (o_note_valid) note_ev <= {o_note_on, o_note_part, o_note_num, o_note_vel};
      if (o_kill_valid) kill_ev <= {o_kill_part, o_kill_hard};
      if (cyc == 20000) begin
         n_mismatch++;
         final_report;
      end
   end
   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge I_SYS_CLK);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge I_SYS_CLK);
      i_penable <= 1'b1;
      do @(posedge I_SYS_CLK); while (o_pready !== 1'b1);
      r = o_prdata;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(r & m, e);
   endtask
   task automatic msg(input logic [23:0] m, input int n);
      link_i.send(m, n);
      repeat (3) @(posedge I_SYS_CLK);
   endtask
   task automatic knob(input logic [6:0] v);
      @(posedge I_SYS_CLK);
      i_knob_turn <= 1'b1;
      i_knob_value <= v;
      @(posedge I_SYS_CLK);
      i_knob_turn <= 1'b0;
   endtask
   // Collect three sent bytes; timeout covers a missing frame
   task automatic txw();
      while (link_i.got.size() < 3) @(posedge I_SYS_CLK);
      r = {8'h00, link_i.got[0], link_i.got[1], link_i.got[2]};
      link_i.got.delete();
   endtask
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Test sequence
   initial begin
      repeat (20) @(posedge I_SYS_CLK);
      I_RST <= 1'b0;
      msg(24'h933C40, 3);
      chk(note_ev, {1'b1, 4'h3, 7'h3C, 7'h40});
      msg(24'h3C00, 2);
      chk(note_ev, {1'b0, 4'h3, 7'h3C, 7'h00});
      msg(24'h833D7F, 3);
      chk(note_ev, {1'b0, 4'h3, 7'h3D, 7'h00});
      $display("Test notes done");
      apb(1'b1, `MCVD_REG_CHSEL, 32'h5);
      msg(24'hE5117F, 3);
      msg(24'hB54040, 3);
      msg(24'h413F, 2);
      msg(24'h427F, 2);
      msg(24'h0122, 2);
      msg(24'h0B10, 2);
      rdc(`MCVD_REG_CHSTAT, 32'hFFFFFFFF, {4'h5, 14'h3F91, 7'h22, 7'h10});
      msg(24'h7800, 2);
      chk(kill_ev, {4'h5, 1'b1});
      rdc(`MCVD_REG_CHSTAT, 32'h70000000, 32'h50000000);
      msg(24'h7B00, 2);
      chk(kill_ev, {4'h5, 1'b0});
      msg(24'h0612, 2);
      msg(24'h6500, 2);
      msg(24'h6400, 2);
      rdc(`MCVD_REG_CHPARAM, 32'hFFFFFFFF, 32'h0);
      msg(24'h0603, 2);
      msg(24'h2604, 2);
      msg(24'h607F, 2);
      rdc(`MCVD_REG_CHPARAM, 32'hFFFFFFFF, 32'h185);
      msg(24'h7900, 2);
      msg(24'h0677, 2);
      rdc(`MCVD_REG_CHSTAT, 32'hFFFFFFFF, {4'h0, 14'h2000, 7'h00, 7'h7F});
      rdc(`MCVD_REG_CHPARAM, 32'hFFFFFFFF, {4'h0, 14'h3FFF, 14'h0185});
      msg(24'hB50355, 3);
      msg(24'h954001, 3);
      chk(note_ev, {1'b1, 4'h5, 7'h40, 7'h01});
      $display("Test controls done");
      msg(24'hC52A, 2);
      rdc(`MCVD_REG_NOTE, 32'hFE000000, {7'h2A, 25'h0});
      msg(24'hB50000, 3);
      for (i = 0; i < 5; i++) begin
         bh = (i == 0) ? 8'h00 : (i == 1) ? 8'h3F : (i == 2) ? 8'h40 : (i == 3) ? 8'h7E : 8'h7F;
         bl = (i == 1) ? 8'h09 : (i == 2) ? 8'h01 : 8'h00;
         msg({16'h0000, bh}, 2);
         msg({8'h00, 8'h20, bl}, 2);
         msg({8'h00, 8'h20, bl + 8'h01}, 2);
         rdc(`MCVD_REG_NOTE, 32'h01FFF800, {7'h00, bh[6:0], bl[6:0], 11'h0});
      end
      msg(24'h0005, 2);
      rdc(`MCVD_REG_NOTE, 32'h01FC0000, {7'h00, 7'h7F, 18'h0});
      msg(24'h5E7F, 2);
      rdc(`MCVD_REG_NOTE, 32'h7F0, 32'h0);
      msg(24'h5E40, 2);
      rdc(`MCVD_REG_NOTE, 32'h7F0, 32'h7F0);
      apb(1'b1, `MCVD_REG_CTRL, 32'h6);
      msg(24'h417F, 2);
      msg(24'h4C7F, 2);
      rdc(`MCVD_REG_CHSTAT, 32'h20000000, 32'h0);
      rdc(`MCVD_REG_NOTE, 32'hF, 32'hF);
      apb(1'b1, `MCVD_REG_CTRL, 32'h0);
      msg(24'h417F, 2);
      rdc(`MCVD_REG_CHSTAT, 32'h20000000, 32'h20000000);
      $display("Test banks done");
      rdc(`MCVD_REG_KNOB, 32'hFF, 32'h01);
      rdc(12'h100, 32'hFFFFFFFF, 32'h0);
      apb(1'b1, `MCVD_REG_TX, 32'h2);
      apb(1'b1, `MCVD_REG_KNOB, 32'h07);
      link_i.slow = 1'b1;
      knob(7'h33);
      txw();
      chk(r, 32'hB20733);
      apb(1'b1, `MCVD_REG_KNOB, 32'h80);
      knob(7'h33);
      txw();
      chk(r, 32'hE20033);
      apb(1'b1, `MCVD_REG_KNOB, 32'h20);
      knob(7'h11);
      apb(1'b1, `MCVD_REG_CTRL, 32'h0);
      i_foot_switch <= 1'b1;
      repeat (12) @(posedge I_SYS_CLK);
      chk(link_i.got.size(), 0);
      i_foot_switch <= 1'b0;
      apb(1'b1, `MCVD_REG_CTRL, 32'h1);
      i_foot_switch <= 1'b1;
      txw();
      chk(r & 32'hFFFF40, 32'hB24040);
      i_foot_switch <= 1'b0;
      txw();
      chk(r & 32'hFFFF40, 32'hB24000);
      $display("Test transmit done");
      final_report;
   end
endmodule

// ### verilog/mcvd_top.v
// Channel voice decoder and knob/foot-switch controller sender with APB registers
//
// Contract
// - Note-off releases note, velocity ignored, never sent
// - Note-on velocity zero acts as release
// - Program change selects program for channel
// - Bend: low seven bits then high seven
// - Bend high byte 00/40/7F low/center/high
// - Control change: number byte then value byte
// - Bank high selects voice bank class
// - Bank low range limited by bank high
// - Switch controllers on at 64 and above
// - Offset controllers map 64 to zero
// - Data entry acts only on selected parameter
// - Portamento ignored for rhythm; time stored raw
// - Controller 94 sets dry/variation balance
// - Message goes to part matching its channel
// - All sound off silences, keeps switches
// - Reset all restores bend, mod, expr, switches
// - Reset all nulls parameter selection only
// - All notes off spares sustained notes
// - Foot switch sends sustain only when configured
// - Knobs send CC 1-119 except 32, or bend
// - Tempo lock turns LFO speed into note lengths; here the tempo bit is only read back beside LFO speed bits 6:4
`timescale 1ns/1ps
`include "mcvd_defs.vh"

module mcvd_top (
   // Clock and reset
   input  wire        I_SYS_CLK,
   input  wire        I_RST,
   // APB slave
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [11:0] i_paddr,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output wire        o_pready,
   output wire        o_pslverr,
   // Received byte stream
   input  wire        i_rx_valid,
   input  wire [7:0]  i_rx_byte,
   // Transmit byte stream
   output reg         o_tx_valid,
   output reg  [7:0]  o_tx_byte,
   input  wire        i_tx_ready,
   // Front panel
   input  wire        i_foot_switch,
   input  wire        i_knob_turn,
   input  wire [6:0]  i_knob_value,
   // Tone generator events
   output reg         o_note_valid,
   output reg         o_note_on,
   output reg  [3:0]  o_note_part,
   output reg  [6:0]  o_note_num,
   output reg  [6:0]  o_note_vel,
   output reg         o_kill_valid,
   output reg  [3:0]  o_kill_part,
   output reg         o_kill_hard
);

   // ==========================================================
   // Parser states
   localparam [2:0] S_STATUS = 3'b001;
   localparam [2:0] S_DATA1  = 3'b010;
   localparam [2:0] S_DATA2  = 3'b100;

   reg [2:0]  st_q;
   reg [7:0]  status_q;
   reg [6:0]  d1_q;

   // Per-part channel state, indexed by channel nibble
   reg [13:0] bend_q      [0:15];
   reg [6:0]  prog_q      [0:15];
   reg [6:0]  mod_q       [0:15];
   reg [6:0]  expr_q      [0:15];
   reg [6:0]  vol_q       [0:15];
   reg [6:0]  pan_q       [0:15];
   reg [6:0]  bank_hi_q   [0:15];
   reg [6:0]  bank_lo_q   [0:15];
   reg [6:0]  porta_t_q   [0:15];
   reg [6:0]  lfo_spd_q   [0:15];
   reg [6:0]  dry_q       [0:15];
   reg [6:0]  var_q       [0:15];
   reg [13:0] param_sel_q [0:15];
   reg [13:0] param_val_q [0:15];
   reg        sus_q       [0:15];
   reg        porta_q     [0:15];
   reg        sost_q      [0:15];

   // Configuration registers
   reg [2:0]  ctrl_q;
   reg [7:0]  knob_cfg_q;   // [6:0] controller, [7] send bend instead
   reg [3:0]  tx_ch_q;
   reg [3:0]  ch_sel_q;
   reg        foot_prev_q;

   // ==========================================================
   // Byte classification
   wire       is_status = i_rx_valid & i_rx_byte[7];
   wire       is_data   = i_rx_valid & ~i_rx_byte[7];
   wire [3:0] kind      = status_q[7:4];
   wire [3:0] ch        = status_q[3:0];
   wire       one_data  = (kind == `MCVD_ST_PROG);
   wire       known     = (kind == `MCVD_ST_NOTE_OFF) | (kind == `MCVD_ST_NOTE_ON) |
                          (kind == `MCVD_ST_CTRL) | (kind == `MCVD_ST_PROG) |
                          (kind == `MCVD_ST_BEND);
   wire       msg_done  = is_data & ((st_q == S_DATA2) | ((st_q == S_DATA1) & one_data));
   wire [6:0] v         = i_rx_byte[6:0];
   wire       sw_on     = v[`MCVD_SWITCH_BIT];

   // Bank low limit by bank class
   reg        bank_lo_ok;
   always @* begin
      case (bank_hi_q[ch])
         `MCVD_BANK_PRESET: bank_lo_ok = (v <= `MCVD_BANK_PRE_MAX);
         `MCVD_BANK_SAMPLE: bank_lo_ok = (v <= `MCVD_BANK_SMP_MAX);
         default:           bank_lo_ok = (v == 7'h00);
      endcase
   end

   // Bank high accepted only for the five documented classes
   wire bank_hi_ok = (v == `MCVD_BANK_STD) | (v == `MCVD_BANK_PRESET) |
                     (v == `MCVD_BANK_SAMPLE) | (v == `MCVD_BANK_PDRUM) |
                     (v == `MCVD_BANK_SDRUM);
   wire rhythm = ctrl_q[`MCVD_CTRL_RHYTHM];
   wire ccm    = msg_done & (kind == `MCVD_ST_CTRL);
   wire zero_v = (v == 7'h00);

   // Dry/variation balance; dry 7F up to 64, falls by 2 per step, 00 at 127; variation 2*v below 64, 7E from 64, 7F at 127
   wire [6:0] dry_v = ~v[6] ? 7'h7F : (v == 7'h7F) ? 7'h00 : 7'h7F - {v[5:0], 1'b0};
   wire [6:0] var_v = v[6] ? ((v == 7'h7F) ? 7'h7F : 7'h7E) : {v[5:0], 1'b0};

   // ==========================================================
   // Parser sequencing; running status keeps last status
   always @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         st_q     <= S_STATUS;
         status_q <= 8'h00;
         d1_q     <= 7'h00;
      end else begin
         case (st_q)
            S_STATUS: begin
               if (is_status) begin
                  status_q <= i_rx_byte;
                  st_q     <= S_DATA1;
               end
            end
            S_DATA1: begin
               if (is_status) begin
                  status_q <= i_rx_byte;
               end else if (is_data) begin
                  d1_q <= v;
                  if (!one_data) begin
                     st_q <= S_DATA2;
                  end
               end
            end
            S_DATA2: begin
               if (is_status) begin
                  status_q <= i_rx_byte;
                  st_q     <= S_DATA1;
               end else if (is_data) begin
                  st_q <= S_DATA1;                          // Running status
               end
            end
            default: st_q <= S_STATUS;
         endcase
      end
   end

   // ==========================================================
   // Note and kill events, one-cycle pulses
   always @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         o_note_valid <= 1'b0;
         o_note_on    <= 1'b0;
         o_note_part  <= 4'h0;
         o_note_num   <= 7'h00;
         o_note_vel   <= 7'h00;
         o_kill_valid <= 1'b0;
         o_kill_part  <= 4'h0;
         o_kill_hard  <= 1'b0;
      end else begin
         o_note_valid <= msg_done & known &
                         ((kind == `MCVD_ST_NOTE_OFF) | (kind == `MCVD_ST_NOTE_ON));
         o_kill_valid <= 1'b0;
         if (msg_done) begin
            o_note_part <= ch;
            o_note_num  <= d1_q;
            o_note_on   <= (kind == `MCVD_ST_NOTE_ON) & ~zero_v;
            o_note_vel  <= (kind == `MCVD_ST_NOTE_ON) ? v : 7'h00;
            o_kill_part <= ch;
            if (ccm & zero_v & (d1_q == `MCVD_CC_SOUND_OFF)) begin
               o_kill_valid <= 1'b1;
               o_kill_hard  <= 1'b1;
            end else if (ccm & zero_v & (d1_q == `MCVD_CC_NOTES_OFF)) begin
               o_kill_valid <= 1'b1;
               o_kill_hard  <= 1'b0;    // Tone generator spares sustained notes
            end
         end
      end
   end

   // ==========================================================
   // Per-part state, one generate slice per channel
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_part
         wire hit = msg_done & (ch == g);
         wire cc  = hit & (kind == `MCVD_ST_CTRL);
         wire sel_null = (param_sel_q[g] == `MCVD_PARAM_NULL);
         always @(posedge I_SYS_CLK or posedge I_RST) begin
            if (I_RST) begin
               bend_q[g]      <= `MCVD_BEND_CENTER;
               prog_q[g]      <= 7'h00;
               mod_q[g]       <= 7'h00;
               expr_q[g]      <= `MCVD_EXPR_MAX;
               vol_q[g]       <= 7'h64;
               pan_q[g]       <= `MCVD_OFFSET_ZERO;
               bank_hi_q[g]   <= 7'h00;
               bank_lo_q[g]   <= 7'h00;
               porta_t_q[g]   <= 7'h00;
               lfo_spd_q[g]   <= `MCVD_OFFSET_ZERO;
               dry_q[g]       <= 7'h7F;
               var_q[g]       <= 7'h00;
               param_sel_q[g] <= `MCVD_PARAM_NULL;
               param_val_q[g] <= 14'h0000;
               sus_q[g]       <= 1'b0;
               porta_q[g]     <= 1'b0;
               sost_q[g]      <= 1'b0;
            end else begin
               if (hit & (kind == `MCVD_ST_PROG)) begin
                  prog_q[g] <= v;
               end
               if (hit & (kind == `MCVD_ST_BEND)) begin
                  bend_q[g] <= {v, d1_q};
               end
               if (cc) begin
                  case (d1_q)
                     `MCVD_CC_BANK_HI:   if (bank_hi_ok) bank_hi_q[g] <= v;
                     `MCVD_CC_BANK_LO:   if (bank_lo_ok) bank_lo_q[g] <= v;
                     `MCVD_CC_MOD:       mod_q[g]  <= v;
                     `MCVD_CC_VOLUME:    vol_q[g]  <= v;
                     `MCVD_CC_PAN:       pan_q[g]  <= v;
                     `MCVD_CC_EXPR:      expr_q[g] <= v;
                     `MCVD_CC_PORTA_TIME: if (!rhythm) porta_t_q[g] <= v;
                     `MCVD_CC_PORTA_SW:  if (!rhythm) porta_q[g] <= sw_on;
                     `MCVD_CC_SUSTAIN:   sus_q[g]  <= sw_on;
                     `MCVD_CC_SOSTENUTO: sost_q[g] <= sw_on;
                     `MCVD_CC_LFO_SPEED: lfo_spd_q[g] <= v;
                     `MCVD_CC_DRYVAR: begin
                        dry_q[g] <= dry_v;
                        var_q[g] <= var_v;
                     end
                     `MCVD_CC_PARAM_LO:  param_sel_q[g][6:0]  <= v;
                     `MCVD_CC_PARAM_HI:  param_sel_q[g][13:7] <= v;
                     `MCVD_CC_DATA_HI:   if (!sel_null) param_val_q[g][13:7] <= v;
                     `MCVD_CC_DATA_LO:   if (!sel_null) param_val_q[g][6:0]  <= v;
                     `MCVD_CC_INC: if (!sel_null && param_val_q[g] != 14'h3FFF)
                        param_val_q[g] <= param_val_q[g] + 14'h0001;
                     `MCVD_CC_DEC: if (!sel_null && param_val_q[g] != 14'h0000)
                        param_val_q[g] <= param_val_q[g] - 14'h0001;
                     `MCVD_CC_RESET_ALL: if (v == 7'h00) begin
                        bend_q[g]      <= `MCVD_BEND_CENTER;
                        mod_q[g]       <= 7'h00;
                        expr_q[g]      <= `MCVD_EXPR_MAX;
                        sus_q[g]       <= 1'b0;
                        porta_q[g]     <= 1'b0;
                        sost_q[g]      <= 1'b0;
                        param_sel_q[g] <= `MCVD_PARAM_NULL;
                     end
                     default: ;  // Switches untouched on sound off
                  endcase
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // Transmit: knob control change / bend, foot switch sustain
   localparam [3:0] T_IDLE = 4'b0001;
   localparam [3:0] T_B0   = 4'b0010;
   localparam [3:0] T_B1   = 4'b0100;
   localparam [3:0] T_B2   = 4'b1000;
   reg [3:0] tst_q;
   reg [7:0] tb0_q;
   reg [6:0] tb1_q;
   reg [6:0] tb2_q;
   wire knob_ok = knob_cfg_q[7] |
                  ((knob_cfg_q[6:0] >= 7'h01) & (knob_cfg_q[6:0] <= 7'h77) &
                   (knob_cfg_q[6:0] != `MCVD_CC_BANK_LO));
   wire foot_edge = (i_foot_switch != foot_prev_q) &
                    ctrl_q[`MCVD_CTRL_FOOT_SUS];
   // Last byte of the previous frame must be taken before a new frame
   wire tx_free   = ~o_tx_valid | i_tx_ready;

   // Byte sender; no note-off status is ever produced
   always @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         tst_q       <= T_IDLE;
         tb0_q       <= 8'h00;
         tb1_q       <= 7'h00;
         tb2_q       <= 7'h00;
         o_tx_valid  <= 1'b0;
         o_tx_byte   <= 8'h00;
         foot_prev_q <= 1'b0;
      end else begin
         case (tst_q)
            T_IDLE: begin
               // Foot edge is only consumed when a message can start; a pending
               // third byte would otherwise be overwritten by the next status
               if (foot_edge & tx_free) begin
                  foot_prev_q <= i_foot_switch;
                  tb0_q <= {`MCVD_ST_CTRL, tx_ch_q};
                  tb1_q <= `MCVD_CC_SUSTAIN;
                  tb2_q <= i_foot_switch ? 7'h7F : 7'h00;
                  tst_q <= T_B0;
               end else if (i_knob_turn & knob_ok & tx_free) begin
                  foot_prev_q <= ctrl_q[`MCVD_CTRL_FOOT_SUS] ? foot_prev_q : i_foot_switch;
                  tb0_q <= {knob_cfg_q[7] ? `MCVD_ST_BEND : `MCVD_ST_CTRL, tx_ch_q};
                  tb1_q <= knob_cfg_q[7] ? 7'h00 : knob_cfg_q[6:0];
                  tb2_q <= i_knob_value;
                  tst_q <= T_B0;
               end else begin
                  foot_prev_q <= ctrl_q[`MCVD_CTRL_FOOT_SUS] ? foot_prev_q : i_foot_switch;
               end
            end
            T_B0: begin
               o_tx_valid <= 1'b1;
               o_tx_byte  <= tb0_q;
               tst_q      <= T_B1;
            end
            T_B1: if (i_tx_ready) begin
               o_tx_byte <= {1'b0, tb1_q};
               tst_q     <= T_B2;
            end
            T_B2: if (i_tx_ready) begin
               o_tx_byte <= {1'b0, tb2_q};
               tst_q     <= T_IDLE;
            end
            default: tst_q <= T_IDLE;
         endcase
         if ((tst_q == T_IDLE) & i_tx_ready) begin
            o_tx_valid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // APB slave: zero wait states, writes at access phase
   wire apb_wr = i_psel & i_penable & i_pwrite;
   assign o_pready  = 1'b1;
   assign o_pslverr = 1'b0;

   always @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         ctrl_q     <= 3'b000;
         knob_cfg_q <= 8'h01;
         tx_ch_q    <= 4'h0;
         ch_sel_q   <= 4'h0;
      end else if (apb_wr) begin
         case (i_paddr)
            `MCVD_REG_CTRL:  ctrl_q     <= i_pwdata[2:0];
            `MCVD_REG_KNOB:  knob_cfg_q <= i_pwdata[7:0];
            `MCVD_REG_TX:    tx_ch_q    <= i_pwdata[3:0];
            `MCVD_REG_CHSEL: ch_sel_q   <= i_pwdata[3:0];
            default: ;
         endcase
      end
   end

   // Read mux, combinational view of the selected part
   always @* begin
      case (i_paddr)
         `MCVD_REG_CTRL:    o_prdata = {29'h0, ctrl_q};
         `MCVD_REG_KNOB:    o_prdata = {24'h0, knob_cfg_q};
         `MCVD_REG_TX:      o_prdata = {28'h0, tx_ch_q};
         `MCVD_REG_CHSEL:   o_prdata = {28'h0, ch_sel_q};
         `MCVD_REG_CHSTAT:  o_prdata = {1'b0, sost_q[ch_sel_q], porta_q[ch_sel_q],
                                       sus_q[ch_sel_q], bend_q[ch_sel_q],
                                       mod_q[ch_sel_q], expr_q[ch_sel_q]};
         `MCVD_REG_CHPARAM: o_prdata = {4'h0, param_sel_q[ch_sel_q], param_val_q[ch_sel_q]};
         `MCVD_REG_NOTE:    o_prdata = {prog_q[ch_sel_q], bank_hi_q[ch_sel_q],
                                       bank_lo_q[ch_sel_q], dry_q[ch_sel_q],
                                       ctrl_q[`MCVD_CTRL_TEMPO],
                                       lfo_spd_q[ch_sel_q][6:4]};
         default:           o_prdata = 32'h0;
      endcase
   end

endmodule
